// [hw/pin_select_pkg.sv]
// Shared constants and types for the remappable pin select block
package pin_select_pkg;

    // Sizes
    localparam int unsigned NUM_PINS     = 16;
    localparam int unsigned IN_REGS      = 9;
    localparam int unsigned OUT_REGS     = 8;
    localparam int unsigned NUM_INPUTS   = 14;
    localparam int unsigned NUM_OUTPUTS  = 7;
    localparam int unsigned SEL_W        = 5;
    localparam int unsigned REG_W        = 16;

    // Register indices on the map write and read ports
    localparam logic [4:0] IN_BASE_IDX   = 5'h00;
    localparam logic [4:0] OUT_BASE_IDX  = 5'h09;
    localparam logic [4:0] OSC_RD_IDX    = 5'h11;

    // Lock bit position in the oscillator control low byte
    localparam int unsigned LOCK_BIT     = 6;

    // Unlock keys
    localparam logic [7:0] UNLOCK_KEY1   = 8'h46;
    localparam logic [7:0] UNLOCK_KEY2   = 8'h57;

    // Reset values
    localparam logic       LOCK_RST      = 1'b0;
    localparam logic [15:0] OUT_RST      = 16'h0000;

    // Implemented field bits of each input map register, also its reset value
    localparam logic [15:0] IN_MASK [IN_REGS] = '{
        16'h1F00, 16'h001F, 16'h1F1F, 16'h1F1F, 16'h1F1F,
        16'h001F, 16'h1F1F, 16'h1F1F, 16'h001F};
    localparam logic [15:0] OUT_MASK     = 16'h1F1F;

    // Peripheral input order on periph_in_o
    localparam int unsigned IN_EXT_IRQ_ONE  = 0;
    localparam int unsigned IN_EXT_IRQ_TWO  = 1;
    localparam int unsigned IN_TIMER_B_CLK  = 2;
    localparam int unsigned IN_TIMER_C_CLK  = 3;
    localparam int unsigned IN_CAPTURE_A    = 4;
    localparam int unsigned IN_CAPTURE_B    = 5;
    localparam int unsigned IN_CAPTURE_G    = 6;
    localparam int unsigned IN_CAPTURE_H    = 7;
    localparam int unsigned IN_CMP_FAULT    = 8;
    localparam int unsigned IN_SERIAL_RX    = 9;
    localparam int unsigned IN_SERIAL_CTS   = 10;
    localparam int unsigned IN_SYNC_DATA    = 11;
    localparam int unsigned IN_SYNC_CLOCK   = 12;
    localparam int unsigned IN_SYNC_SELECT  = 13;

    // Register and field low bit of each peripheral input select field
    localparam int unsigned IN_REG [NUM_INPUTS] = '{0, 1, 2, 2, 3, 3, 4, 4, 5, 6, 6, 7, 7, 8};
    localparam int unsigned IN_LSB [NUM_INPUTS] = '{8, 0, 0, 8, 0, 8, 0, 8, 0, 0, 8, 0, 8, 0};

    // Input select code that ties the input low
    localparam logic [4:0] IN_SEL_TIE_LOW   = 5'h1F;

    // Output select codes
    localparam logic [4:0] OUT_SEL_NULL     = 5'h00;
    localparam logic [4:0] OUT_SEL_TX       = 5'h03;
    localparam logic [4:0] OUT_SEL_RTS      = 5'h04;
    localparam logic [4:0] OUT_SEL_SDO      = 5'h07;
    localparam logic [4:0] OUT_SEL_SCK      = 5'h08;
    localparam logic [4:0] OUT_SEL_SS       = 5'h09;
    localparam logic [4:0] OUT_SEL_OC_A     = 5'h12;
    localparam logic [4:0] OUT_SEL_OC_B     = 5'h13;

    // Peripheral output order on the internal output vector
    localparam int unsigned OUT_TX   = 0;
    localparam int unsigned OUT_RTS  = 1;
    localparam int unsigned OUT_SDO  = 2;
    localparam int unsigned OUT_SCK  = 3;
    localparam int unsigned OUT_SS   = 4;
    localparam int unsigned OUT_OC_A = 5;
    localparam int unsigned OUT_OC_B = 6;

    // Disturbance injected into input map register 0 for the shadow check
    localparam logic [15:0] UPSET_FLIP = 16'h0100;

    // Unlock sequence, Gray along the key path
    typedef enum logic [1:0] {
        SEQ_IDLE  = 2'b00,
        SEQ_KEY1  = 2'b01,
        SEQ_ARMED = 2'b11
    } unlock_e;

endpackage

// [hw/remap_out_select.sv]
// Output select decoder for one remappable pin
`timescale 1ns/1ps
`default_nettype none

module remap_out_select
    import pin_select_pkg::*;
(
    input  wire logic [SEL_W-1:0]       sel_i,      // Output select field
    input  wire logic [NUM_OUTPUTS-1:0] periph_i,   // Peripheral outputs
    input  wire logic                   port_i,     // Default port data
    output logic                        data_o      // Pin data
);

    // Unlisted codes fall back to the port, same as null
    always_comb
    begin
        unique case (sel_i)
            OUT_SEL_TX:   data_o = periph_i[OUT_TX];
            OUT_SEL_RTS:  data_o = periph_i[OUT_RTS];
            OUT_SEL_SDO:  data_o = periph_i[OUT_SDO];
            OUT_SEL_SCK:  data_o = periph_i[OUT_SCK];
            OUT_SEL_SS:   data_o = periph_i[OUT_SS];
            OUT_SEL_OC_A: data_o = periph_i[OUT_OC_A];
            OUT_SEL_OC_B: data_o = periph_i[OUT_OC_B];
            default:      data_o = port_i;
        endcase
    end

endmodule // remap_out_select

`default_nettype wire

// [hw/remappable_pin_select.sv]
// Remappable pin select: mapping registers, lock, shadow check, pin muxes
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Each pin has a 5-bit output select
// - Null code gives pin its port function
// - Codes 03/04 route serial TX/RTS
// - Codes 07/08/09 route sync data/clock/select
// - Codes 12/13 route compare A/B
// - Fourteen 5-bit peripheral input select fields
// - Input field value n selects pin n
// - Locked writes accepted but change nothing
// - Lock bit at bit 6 gates writes
// - Keys 46 then 57 before lock change
// - Lock holds until software changes it
// - Shadow mismatch raises configuration reset
// - One-way option forbids clearing lock again
// - One-way set allows one session only
// - Nine input, eight output mapping registers
module remappable_pin_select
    import pin_select_pkg::*;
(
    input  wire logic                   clock_i,            // 40 MHz clock
    input  wire logic                   reset_n_i,          // Sync reset, active low
    input  wire logic                   map_wr_i,           // Map register write strobe
    input  wire logic [4:0]             map_wr_index_i,     // Map register index
    input  wire logic [REG_W-1:0]       map_wr_data_i,      // Map register write data
    input  wire logic                   osc_wr_i,           // Osc control low byte write
    input  wire logic [7:0]             osc_wdata_i,        // Osc control low byte data
    input  wire logic                   one_way_lock_cfg_i, // One-way lock option
    input  wire logic [4:0]             rd_index_i,         // Read index
    output logic      [REG_W-1:0]       rd_data_o,          // Read data, one cycle later
    output logic                        map_write_lock_o,   // Lock bit state
    output logic                        cfg_mismatch_o,     // Mismatch reset request
    input  wire logic                   upset_inject_i,     // Flip a stored map bit
    input  wire logic [NUM_PINS-1:0]    remap_pin_i,        // Pin input levels
    output logic      [NUM_PINS-1:0]    remap_pin_o,        // Pin output data
    output logic      [NUM_PINS-1:0]    remap_pin_oe_o,     // Pin drive enable
    input  wire logic [NUM_PINS-1:0]    port_out_i,         // Default port data
    input  wire logic [NUM_PINS-1:0]    pin_direction_oe_i, // Port drive enables
    input  wire logic                   serial_tx_out_i,    // Serial transmit
    input  wire logic                   serial_rts_out_i,   // Serial request to send
    input  wire logic                   sync_data_out_i,    // Sync data out
    input  wire logic                   sync_clock_out_i,   // Sync clock out
    input  wire logic                   sync_select_out_i,  // Sync select out
    input  wire logic                   compare_out_a_i,    // Compare channel 1
    input  wire logic                   compare_out_b_i,    // Compare channel 2
    output logic      [NUM_INPUTS-1:0]  periph_in_o         // Peripheral inputs
);

    typedef struct packed {
        logic [IN_REGS-1:0][REG_W-1:0]  in_map;
        logic [IN_REGS-1:0][REG_W-1:0]  in_shadow;
        logic [OUT_REGS-1:0][REG_W-1:0] out_map;
        logic [OUT_REGS-1:0][REG_W-1:0] out_shadow;
        logic                           lock;
        logic                           lock_once;
        unlock_e                        seq;
        logic                           mismatch;
        logic [NUM_INPUTS-1:0]          periph_in;
        logic [NUM_PINS-1:0]            pin_data;
        logic [NUM_PINS-1:0]            pin_oe;
        logic [REG_W-1:0]               rd_data;
    } state_s;

    state_s                   state_r;
    state_s                   state_nxt;
    logic [NUM_OUTPUTS-1:0]   periph_out;
    logic [NUM_PINS-1:0]      pin_mux;
    logic                     in_hit;
    logic                     out_hit;
    logic [3:0]               in_sel;
    logic [2:0]               out_sel;
    logic                     lock_req;

    // Peripheral outputs gathered in select order
    assign periph_out = {compare_out_b_i, compare_out_a_i, sync_select_out_i,
                         sync_clock_out_i, sync_data_out_i, serial_rts_out_i,
                         serial_tx_out_i};

    // Write index decode, out of range indices are dropped
    assign in_hit  = (map_wr_index_i < OUT_BASE_IDX);
    assign out_hit = (map_wr_index_i >= OUT_BASE_IDX) && (map_wr_index_i < OSC_RD_IDX);
    assign in_sel  = map_wr_index_i[3:0];
    assign out_sel = 3'(map_wr_index_i - OUT_BASE_IDX);
    assign lock_req = osc_wdata_i[LOCK_BIT];

    // One decoder per pin, fed by its own 5-bit field
    genvar p;
    generate
        for (p = 0; p < NUM_PINS; p++)
        begin : g_pin
            remap_out_select u_sel (
                .sel_i    (state_r.out_map[p / 2][(p % 2) * 8 +: SEL_W]),
                .periph_i (periph_out),
                .port_i   (port_out_i[p]),
                .data_o   (pin_mux[p])
            );
        end
    endgenerate

    // Next state: writes, lock sequence, shadow check, muxes, read back
    always_comb
    begin
        logic [SEL_W-1:0] field;
        field     = '0;
        state_nxt = state_r;

        // Map writes land in register and shadow together
        if (map_wr_i && !state_r.lock)
        begin
            if (in_hit)
            begin
                state_nxt.in_map[in_sel]    = map_wr_data_i & IN_MASK[in_sel];
                state_nxt.in_shadow[in_sel] = map_wr_data_i & IN_MASK[in_sel];
            end
            else if (out_hit)
            begin
                state_nxt.out_map[out_sel]    = map_wr_data_i & OUT_MASK;
                state_nxt.out_shadow[out_sel] = map_wr_data_i & OUT_MASK;
            end
        end

        // Disturbance skips the shadow so the monitor sees it
        if (upset_inject_i)
        begin
            state_nxt.in_map[0] = state_nxt.in_map[0] ^ UPSET_FLIP;
        end

        // Unlock sequence; any stray write restarts it
        if (osc_wr_i)
        begin
            unique case (state_r.seq)
                SEQ_ARMED:
                begin
                    state_nxt.seq = SEQ_IDLE;
                    // Once set, one-way option pins the lock high
                    if (lock_req || !(one_way_lock_cfg_i && state_r.lock_once))
                    begin
                        // Only this arm moves the lock, so it never relocks alone
                        state_nxt.lock = lock_req;
                    end
                    if (lock_req)
                    begin
                        state_nxt.lock_once = 1'b1;
                    end
                end
                SEQ_KEY1:
                begin
                    state_nxt.seq = (osc_wdata_i == UNLOCK_KEY2) ? SEQ_ARMED :
                                    (osc_wdata_i == UNLOCK_KEY1) ? SEQ_KEY1 : SEQ_IDLE;
                end
                SEQ_IDLE:
                begin
                    state_nxt.seq = (osc_wdata_i == UNLOCK_KEY1) ? SEQ_KEY1 : SEQ_IDLE;
                end
                default:
                begin
                    state_nxt.seq = SEQ_IDLE;
                end
            endcase
        end

        // Sticky until system reset, which this request causes
        if ((state_r.in_map != state_r.in_shadow) || (state_r.out_map != state_r.out_shadow))
        begin
            state_nxt.mismatch = 1'b1;
        end

        // Input routing; codes past the last pin read low
        for (int k = 0; k < NUM_INPUTS; k++)
        begin
            field = state_r.in_map[IN_REG[k]][IN_LSB[k] +: SEL_W];
            if (field == IN_SEL_TIE_LOW || field >= SEL_W'(NUM_PINS))
            begin
                state_nxt.periph_in[k] = 1'b0;
            end
            else
            begin
                state_nxt.periph_in[k] = remap_pin_i[field[3:0]];
            end
        end

        // Direction stays with the port logic, mapping never forces it
        state_nxt.pin_data = pin_mux;
        state_nxt.pin_oe   = pin_direction_oe_i;

        // Read back, unimplemented indices read zero
        if (rd_index_i < OUT_BASE_IDX)
        begin
            state_nxt.rd_data = state_r.in_map[rd_index_i[3:0]];
        end
        else if (rd_index_i < OSC_RD_IDX)
        begin
            state_nxt.rd_data = state_r.out_map[3'(rd_index_i - OUT_BASE_IDX)];
        end
        else if (rd_index_i == OSC_RD_IDX)
        begin
            state_nxt.rd_data = '0;
            state_nxt.rd_data[LOCK_BIT] = state_r.lock;
        end
        else
        begin
            state_nxt.rd_data = '0;
        end

        // Reset values
        if (!reset_n_i)
        begin
            for (int r = 0; r < IN_REGS; r++)
            begin
                state_nxt.in_map[r]    = IN_MASK[r];
                state_nxt.in_shadow[r] = IN_MASK[r];
            end
            for (int r = 0; r < OUT_REGS; r++)
            begin
                state_nxt.out_map[r]    = OUT_RST;
                state_nxt.out_shadow[r] = OUT_RST;
            end
            state_nxt.lock      = LOCK_RST;
            state_nxt.lock_once = 1'b0;
            state_nxt.seq       = SEQ_IDLE;
            state_nxt.mismatch  = 1'b0;
            state_nxt.periph_in = '0;
            state_nxt.pin_data  = '0;
            state_nxt.pin_oe    = '0;
            state_nxt.rd_data   = '0;
        end
    end

    // Single state register
    always_ff @(posedge clock_i)
    begin
        state_r <= state_nxt;
    end

    // Outputs straight from the state flops
    assign rd_data_o        = state_r.rd_data;
    assign map_write_lock_o = state_r.lock;
    assign cfg_mismatch_o   = state_r.mismatch;
    assign remap_pin_o      = state_r.pin_data;
    assign remap_pin_oe_o   = state_r.pin_oe;
    assign periph_in_o      = state_r.periph_in;

    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!reset_n_i);

    a_locked_write_ignored: assert property (
        (state_r.lock && map_wr_i && !upset_inject_i && !osc_wr_i)
        |=> ($stable(state_r.in_map) && $stable(state_r.out_map)))
        else $error("map register changed while locked");

    a_unlocked_write_lands: assert property (
        (!state_r.lock && map_wr_i && map_wr_index_i == IN_BASE_IDX && !upset_inject_i)
        |=> (state_r.in_map[0] == ($past(map_wr_data_i) & IN_MASK[0])))
        else $error("unlocked write not stored");

    a_lock_needs_keys: assert property (
        (osc_wr_i && state_r.seq != SEQ_ARMED) |=> $stable(state_r.lock))
        else $error("lock changed without unlock sequence");

    a_lock_keys_work: assert property (
        (osc_wr_i && osc_wdata_i == UNLOCK_KEY1 && state_r.seq == SEQ_IDLE)
        ##1 (osc_wr_i && osc_wdata_i == UNLOCK_KEY2)
        ##1 (osc_wr_i && osc_wdata_i[LOCK_BIT])
        |=> map_write_lock_o)
        else $error("lock not set after sequence");

    a_lock_holds: assert property (
        !osc_wr_i |=> $stable(map_write_lock_o))
        else $error("lock changed by itself");

    a_one_way_hold: assert property (
        (one_way_lock_cfg_i && state_r.lock && state_r.lock_once) |=> map_write_lock_o)
        else $error("one-way lock was cleared");

    a_null_port_pin: assert property (
        (state_r.out_map[0][4:0] == OUT_SEL_NULL) |=> (remap_pin_o[0] == $past(port_out_i[0])))
        else $error("null code does not give port data");

    a_tx_route_pin: assert property (
        (state_r.out_map[0][4:0] == OUT_SEL_TX) |=> (remap_pin_o[0] == $past(serial_tx_out_i)))
        else $error("serial transmit not routed");

    a_compare_b_route: assert property (
        (state_r.out_map[0][12:8] == OUT_SEL_OC_B) |=> (remap_pin_o[1] == $past(compare_out_b_i)))
        else $error("compare channel 2 not routed");

    a_input_pin_route: assert property (
        (state_r.in_map[8][4:0] == 5'h0E)
        |=> (periph_in_o[IN_SYNC_SELECT] == $past(remap_pin_i[14])))
        else $error("input select does not follow pin");

    a_input_tie_low: assert property (
        (state_r.in_map[0][12:8] == IN_SEL_TIE_LOW) |=> !periph_in_o[IN_EXT_IRQ_ONE])
        else $error("all-ones input code not low");

    a_mismatch_raise: assert property (
        upset_inject_i |-> ##2 cfg_mismatch_o)
        else $error("disturbance not flagged");

endmodule // remappable_pin_select

`default_nettype wire

// [verif/remap_far_side.sv]
// Far-side model: peripheral outputs, port data and external pin levels
`timescale 1ns/1ps
`default_nettype none

module remap_far_side
(
    input  wire logic [15:0] pin_out_i,   // Block pin data
    input  wire logic [15:0] pin_oe_i,    // Block pin drive enables
    output logic      [15:0] pin_level_o, // Resolved pin levels
    output logic      [6:0]  periph_o,    // Peripheral outputs, tx first
    output logic      [15:0] port_o,      // Default port data
    output logic      [15:0] dir_oe_o     // Port drive enables
);
    logic [15:0] ext_r; // Level driven from outside the chip

    // Mapped input pins start as inputs; mapping never overrides this
    initial
    begin
        ext_r    = 16'h0000;
        periph_o = 7'h00;
        port_o   = 16'hFFFF;
        dir_oe_o = 16'h0000;
    end

    // Chip wins where it drives, else the outside level shows
    assign pin_level_o = (pin_oe_i & pin_out_i) | (~pin_oe_i & ext_r);

    // Peripherals all at p, port data inverse, so port and peripheral sources are told apart
    task automatic set_level(input logic p);
        periph_o = {7{p}};
        port_o   = {16{~p}};
    endtask

    task automatic set_pins(input logic [15:0] v);
        ext_r = v;
    endtask

    // Direction is software's job, not the mapping's
    task automatic set_dir(input logic [15:0] m);
        dir_oe_o = m;
    endtask
endmodule // remap_far_side

`default_nettype wire

// [verif/testbench.sv]
// Self-checking testbench for the remappable pin select block
`timescale 1ns/1ps
`default_nettype none

module testbench
    import pin_select_pkg::*;
    ;
    logic        clock_i = 1'b0;
    logic        reset_n_i, map_wr_i, osc_wr_i, one_way, upset;
    logic [4:0]  map_wr_index_i, rd_index_i;
    logic [15:0] map_wr_data_i, rd_data_o, pin_lvl, pin_o, pin_oe, port_out, dir_oe;
    logic [7:0]  osc_wdata_i;
    logic [6:0]  periph;
    logic [13:0] periph_in;
    logic        lock, mism;
    int          err_count = 0;
    int          tests_run = 0;
    logic [15:0] im [9];
    logic [15:0] v, e, pat;
    logic [4:0]  c;
    logic [4:0]  codes [10] = '{5'h00, 5'h03, 5'h04, 5'h07, 5'h08,
                                5'h09, 5'h12, 5'h13, 5'h01, 5'h1F};

    remappable_pin_select dut (
        .clock_i(clock_i), .reset_n_i(reset_n_i), .map_wr_i(map_wr_i),
        .map_wr_index_i(map_wr_index_i), .map_wr_data_i(map_wr_data_i),
        .osc_wr_i(osc_wr_i), .osc_wdata_i(osc_wdata_i), .one_way_lock_cfg_i(one_way),
        .rd_index_i(rd_index_i), .rd_data_o(rd_data_o), .map_write_lock_o(lock),
        .cfg_mismatch_o(mism), .upset_inject_i(upset), .remap_pin_i(pin_lvl),
        .remap_pin_o(pin_o), .remap_pin_oe_o(pin_oe), .port_out_i(port_out),
        .pin_direction_oe_i(dir_oe), .serial_tx_out_i(periph[0]),
        .serial_rts_out_i(periph[1]), .sync_data_out_i(periph[2]),
        .sync_clock_out_i(periph[3]), .sync_select_out_i(periph[4]),
        .compare_out_a_i(periph[5]), .compare_out_b_i(periph[6]),
        .periph_in_o(periph_in));

    remap_far_side far (
        .pin_out_i(pin_o), .pin_oe_i(pin_oe), .pin_level_o(pin_lvl),
        .periph_o(periph), .port_o(port_out), .dir_oe_o(dir_oe));

    // 40 MHz clock
    always #12.5 clock_i = ~clock_i;

    // Every step lands just after an edge, clear of the sampling edge
    task automatic tick;
        @(posedge clock_i);
        #2;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            err_count++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Leading tick keeps a strobe from being raised where it was lowered
    task automatic map_write(input logic [4:0] idx, input logic [15:0] d);
        tick();
        map_wr_index_i = idx;
        map_wr_data_i  = d;
        map_wr_i       = 1'b1;
        tick();
        map_wr_i = 1'b0;
    endtask

    task automatic osc_write(input logic [7:0] d);
        tick();
        osc_wdata_i = d;
        osc_wr_i    = 1'b1;
        tick();
        osc_wr_i = 1'b0;
    endtask

    // Keys and lock byte on three back-to-back edges, strobe held high
    task automatic key_seq(input logic [7:0] d);
        tick();
        osc_wdata_i = 8'h46;
        osc_wr_i    = 1'b1;
        tick();
        osc_wdata_i = 8'h57;
        tick();
        osc_wdata_i = d;
        tick();
        osc_wr_i = 1'b0;
    endtask

    // Read data is registered: one edge after the index is taken
    task automatic read_reg(input logic [4:0] idx, output logic [15:0] q);
        tick();
        rd_index_i = idx;
        tick();
        q = rd_data_o;
    endtask

    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    // Watchdog, well beyond the roughly 240 cycles the tests need
    initial
    begin
        repeat (5000) @(posedge clock_i);
        err_count++;
        report_and_stop();
    end

    initial
    begin
        {reset_n_i, map_wr_i, osc_wr_i, upset} = 4'h0;
        one_way = 1'b0;
        {map_wr_index_i, rd_index_i, osc_wdata_i} = 18'h0;
        map_wr_data_i = 16'h0000;
        repeat (6) @(posedge clock_i);
        #2;
        reset_n_i = 1'b1;
        // Reset state of all seventeen registers and an unimplemented index
        for (int i = 0; i < 17; i++)
        begin
            read_reg(i[4:0], v);
            check(v, (i < 9) ? IN_MASK[i] : 16'h0000);
        end
        read_reg(5'h14, v);
        check(v, 16'h0000);
        far.set_pins(16'hFFFF);
        tick();
        check({2'h0, periph_in}, 16'h0000);
        $display("test reset done");
        // Every listed output code, plus unlisted ones, on both pins of two regs
        for (int pi = 0; pi < 2; pi++)
        begin
            far.set_level(pi[0]);
            foreach (codes[j])
            begin
                c = codes[j];
                map_write(5'h09, {3'h0, c, 3'h0, c});
                map_write(5'h10, {3'h0, c, 3'h0, c});
                tick();
                e = {16{~pi[0]}};
                if (c inside {5'h03, 5'h04, 5'h07, 5'h08, 5'h09, 5'h12, 5'h13})
                    e = e ^ 16'hC003;
                check(pin_o, e);
            end
        end
        read_reg(5'h10, v);
        check(v, 16'h1F1F);
        far.set_dir(16'h8001);
        tick();
        tick();
        check(pin_oe, 16'h8001);
        far.set_dir(16'h0000);
        $display("test outputs done");
        // Input k takes pin k+1
        foreach (im[i])
            im[i] = 16'h0000;
        for (int k = 0; k < 14; k++)
            im[IN_REG[k]] = im[IN_REG[k]] | (16'(k + 1) << IN_LSB[k]);
        foreach (im[i])
            map_write(i[4:0], im[i]);
        foreach (im[i])
        begin
            read_reg(i[4:0], v);
            check(v, im[i]);
        end
        for (int pi = 0; pi < 2; pi++)
        begin
            pat = pi ? 16'h5A5A : 16'hA5A5;
            far.set_pins(pat);
            tick();
            check({2'h0, periph_in}, {2'h0, pat[14:1]});
        end
        // Code with no pin and the all-ones code both read low
        map_write(5'h08, 16'h0010);
        map_write(5'h05, 16'h001F);
        far.set_pins(16'hFFFF);
        tick();
        check({2'h0, periph_in}, 16'h1EFF);
        $display("test inputs done");
        // Lock sessions with the one-way option off
        key_seq(8'h40);
        check({15'h0, lock}, 16'h0001);
        read_reg(5'h11, v);
        check(v & 16'h0040, 16'h0040);
        map_write(5'h00, 16'h0000);
        read_reg(5'h00, v);
        check(v, im[0]);
        osc_write(8'h00);
        check({15'h0, lock}, 16'h0001);
        key_seq(8'h00);
        check({15'h0, lock}, 16'h0000);
        map_write(5'h00, 16'h0000);
        map_write(5'h0A, 16'h1F1F);
        read_reg(5'h00, v);
        check(v, 16'h0000);
        read_reg(5'h0A, v);
        check(v, 16'h1F1F);
        // A wrong byte after the first key drops the sequence
        osc_write(8'h46);
        osc_write(8'h00);
        osc_write(8'h40);
        check({15'h0, lock}, 16'h0000);
        osc_write(8'h46);
        key_seq(8'h40);
        check({15'h0, lock}, 16'h0001);
        // One-way option now holds the lock set
        one_way = 1'b1;
        key_seq(8'h00);
        check({15'h0, lock}, 16'h0001);
        $display("test lock done");
        // Disturbed map register trips the sticky mismatch request
        check({15'h0, mism}, 16'h0000);
        upset = 1'b1;
        tick();
        upset = 1'b0;
        tick();
        check({15'h0, mism}, 16'h0001);
        repeat (3) tick();
        check({15'h0, mism}, 16'h0001);
        reset_n_i = 1'b0;
        tick();
        reset_n_i = 1'b1;
        check({14'h0, mism, lock}, 16'h0000);
        $display("test mismatch done");
        report_and_stop();
    end
endmodule // testbench

`default_nettype wire
